// ==== logic/cwbr_pkg.sv ====
// Constants, codes and register map of the control word bit router.
// Assumes a single 40 MHz clock domain and a 32-bit APB register port.
package cwbr_pkg;

    // ==========================================================
    // Sizes
    localparam int CODE_W  = 7;
    localparam int NBIT    = 16;
    localparam int NDI     = 8;
    localparam int NDEST   = 96;
    localparam int ADDR_W  = 8;
    localparam int IDX_LSB = 2;

    // ==========================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CWDIG  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_PADB   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CWMON  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CWDEST = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_DIDEST = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_USER   = 8'h70;
    localparam logic [ADDR_W-1:0] ADDR_USEND  = 8'h7C;
    localparam logic [ADDR_W-1:0] ADDR_CMDMON = 8'h80;
    localparam logic [ADDR_W-1:0] ADDR_PADMON = 8'h8C;
    localparam logic [ADDR_W-1:0] ADDR_PADA   = 8'h90;

    // ==========================================================
    // Control word source selector
    typedef enum logic [1:0] {
        SRC_OFF  = 2'h0,
        SRC_DIG  = 2'h1,
        SRC_PADA = 2'h2,
        SRC_PADB = 2'h3
    } cwbr_src_type;

    // ==========================================================
    // Destination codes (first code of each group; the names ending in LAST give a group's last code)
    localparam logic [CODE_W-1:0] DEST_OFF        = 7'h00;
    localparam logic [CODE_W-1:0] DEST_MPOT       = 7'h01;
    localparam logic [CODE_W-1:0] DEST_JOG        = 7'h05;
    localparam logic [CODE_W-1:0] DEST_ALARM_RST  = 7'h07;
    localparam logic [CODE_W-1:0] DEST_TRQ_REDUCT = 7'h08;
    localparam logic [CODE_W-1:0] DEST_RAMP       = 7'h0A;
    localparam logic [CODE_W-1:0] DEST_SPDREG     = 7'h0D;
    localparam logic [CODE_W-1:0] DEST_AN_SIGN    = 7'h10;
    localparam logic [CODE_W-1:0] DEST_ZERO_TRQ   = 7'h16;
    localparam logic [CODE_W-1:0] DEST_MULTI_SPD  = 7'h17;
    localparam logic [CODE_W-1:0] DEST_MULTI_RAMP = 7'h1A;
    localparam logic [CODE_W-1:0] DEST_FIELD_LOSS = 7'h1C;
    localparam logic [CODE_W-1:0] DEST_REG_EN     = 7'h1D;
    localparam logic [CODE_W-1:0] DEST_PADA       = 7'h21;
    localparam logic [CODE_W-1:0] DEST_PADA_LAST  = 7'h30;
    localparam logic [CODE_W-1:0] DEST_DIR        = 7'h44;
    localparam logic [CODE_W-1:0] DEST_AN_EN      = 7'h46;
    localparam logic [CODE_W-1:0] DEST_DROOP      = 7'h49;
    localparam logic [CODE_W-1:0] DEST_DIG_MODE   = 7'h4A;
    localparam logic [CODE_W-1:0] DEST_DIG_LAST   = 7'h4C;
    localparam logic [CODE_W-1:0] DEST_BRAKE      = 7'h54;
    localparam logic [CODE_W-1:0] DEST_ADAPT      = 7'h56;
    localparam logic [CODE_W-1:0] DEST_EXT_FIELD  = 7'h58;
    localparam logic [CODE_W-1:0] DEST_EXT_BRIDGE = 7'h5A;

    // Gaps in the code list behave like the disabled code
    function automatic logic cwbr_valid(input logic [CODE_W-1:0] c);
        return (c >= DEST_MPOT && c <= DEST_TRQ_REDUCT)
            || (c >= DEST_RAMP && c <= DEST_PADA_LAST)
            || (c >= DEST_DIR && c <= DEST_DIG_LAST)
            || (c == DEST_BRAKE)
            || (c >= DEST_ADAPT && c <= DEST_EXT_BRIDGE);
    endfunction : cwbr_valid

endpackage : cwbr_pkg

// ==== logic/cwbr_route_if.sv ====
// Routed destination flags and values between a router and its user.
// Assumes the cwbr_pkg sizes.
`timescale 1ns/100ps
interface cwbr_route_if
    import cwbr_pkg::*;
();
    logic [NDEST-1:0] drv;
    logic [NDEST-1:0] val;
    modport src (output drv, output val);
    modport snk (input drv, input val);
endinterface : cwbr_route_if

// ==== logic/cwbr_route.sv ====
// Maps a word of source bits onto destination lines by per-bit codes.
// Assumes codes are stable registers; purely combinational.
`timescale 1ns/100ps
module cwbr_route
    import cwbr_pkg::*;
#(
    parameter int NSRC = NBIT
) (
    // Source bits and their destination codes
    input wire logic [NSRC-1:0]             srcWord,
    input wire logic [NSRC-1:0][CODE_W-1:0] srcDest,
    input wire logic                        routeEn,
    // Routed result
    cwbr_route_if.src                       rt
);

    // ==========================================================
    // Decode
    logic [NDEST-1:0] drvV;
    logic [NDEST-1:0] valV;

    always_comb begin
        drvV = '0;
        valV = '0;
        for (int b = 0; b < NSRC; b++) begin
            if (routeEn && cwbr_valid(srcDest[b])) begin // RULE1 RULE2 RULE23
                drvV[srcDest[b]] = 1'b1;
                valV[srcDest[b]] = valV[srcDest[b]] | srcWord[b];
            end
        end
    end

    assign rt.drv = drvV;
    assign rt.val = valV;

endmodule : cwbr_route

// ==== logic/cwbr_router.sv ====
// Control word bit router: APB registers, two routers, command outputs.
// Assumes APB master on mclk; digital inputs and alarm state are pins.
//
// Contract
// RULE1: each of the sixteen control word bits has its own destination selector
// RULE2: code zero routes the bit nowhere
// RULE3: codes 1 to 4 drive motorpot preset, up, down, invert
// RULE4: codes 5 and 6 drive jog plus and jog minus
// RULE5: code 7 requests alarm reset, effective only once alarm cleared
// RULE6: codes 10 to 12 zero ramp output, zero ramp input, freeze ramp
// RULE7: codes 13 to 15 detach speed regulator, lock integral, flying capture
// RULE8: codes 16 to 21 pick analog input signs, even positive, odd negative
// RULE9: codes 23 to 25 give the three multi-speed selector bits
// RULE10: codes 26 and 27 give the two multi-ramp selector bits
// RULE11: codes 33 to 48 force scratch bitword A bits 0 to 15
// RULE12: codes 68 and 69 drive forward and reverse commands
// RULE13: codes 70 to 72 enable analog inputs, code 73 enables droop
// RULE14: codes 74 to 76 are digital-mode enable, start, fast stop
// RULE15: codes 29 to 32 enable speed reg, field reg, weakening, weakening at 0
// RULE16: code 8 torque reduction, 22 zero torque, 28 external field loss
// RULE17: code 84 brake feedback, codes 86 and 87 adaptive set selector
// RULE18: codes 88 to 90 external field enable, inversion flag, active bridge
// RULE19: same code on a control bit and digital input clears the older one
// RULE20: routed bit overrides the user parameter and shows in its monitor
// RULE21: control word and digital inputs both outrank user parameters
// RULE22: control word monitor is zero when source is off, else the source
// RULE23: undefined codes behave like the disabled code
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module cwbr_router
    import cwbr_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // APB slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins
    input  wire logic [NDI-1:0]    diPin,
    input  wire logic              alarmActive,
    // Drive commands
    output logic [3:0]             mpotCmd,
    output logic [1:0]             jogCmd,
    output logic                   alarmResetReq,
    output logic                   trqReduct,
    output logic [2:0]             rampCmd,
    output logic [2:0]             spdRegCmd,
    output logic [5:0]             anSignSel,
    output logic                   zeroTorque,
    output logic [2:0]             multiSpeedSel,
    output logic [1:0]             multiRampSel,
    output logic                   fieldLossExt,
    output logic [3:0]             regEnable,
    output logic [NBIT-1:0]        padAWord,
    output logic [1:0]             dirCmd,
    output logic [2:0]             anEnable,
    output logic                   droopEnable,
    output logic [2:0]             digModeCmd,
    output logic                   brakeFbk,
    output logic [1:0]             adaptSel,
    output logic                   extFieldCtrlEnable,
    output logic                   extFieldInvSeq,
    output logic                   extFieldActiveBridge
);

    // ==========================================================
    // Registers
    cwbr_src_type                 srcSel_q;
    logic [NBIT-1:0]              cwDig_q;
    logic [NBIT-1:0]              padABase_q;
    logic [NBIT-1:0]              padB_q;
    logic [NBIT-1:0][CODE_W-1:0]  cwDest_q;
    logic [NDI-1:0][CODE_W-1:0]   diDest_q;
    logic [NDEST-1:0]             user_q;
    logic [NDEST-1:0]             cmdState_q;
    logic [NBIT-1:0]              cwMon_q;
    logic [NDI-1:0]               diSync1_q;
    logic [NDI-1:0]               diSync2_q;
    logic                         alarmSync1_q;
    logic                         alarmSync2_q;

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            diSync1_q    <= '0;
            diSync2_q    <= '0;
            alarmSync1_q <= 1'b0;
            alarmSync2_q <= 1'b0;
        end else begin
            diSync1_q    <= diPin;
            diSync2_q    <= diSync1_q;
            alarmSync1_q <= alarmActive;
            alarmSync2_q <= alarmSync1_q;
        end
    end

    // ==========================================================
    // Address decode
    logic [ADDR_W-1:0] cwOff;
    logic [ADDR_W-1:0] diOff;
    logic [ADDR_W-1:0] usOff;
    logic              hitCw;
    logic              hitDi;
    logic              hitUs;
    logic              rdHit;
    logic [31:0]       rdData;
    logic [3:0]        cwIdx;
    logic [2:0]        diIdx;
    logic [1:0]        usIdx;
    logic              setup;
    logic              wrEn;

    assign cwOff = paddr - ADDR_CWDEST;
    assign diOff = paddr - ADDR_DIDEST;
    assign usOff = paddr - ADDR_USER;
    assign cwIdx = cwOff[IDX_LSB +: 4];
    assign diIdx = diOff[IDX_LSB +: 3];
    assign usIdx = usOff[IDX_LSB +: 2];
    assign hitCw = paddr >= ADDR_CWDEST && paddr < ADDR_DIDEST;
    assign hitDi = paddr >= ADDR_DIDEST && paddr < ADDR_USER;
    assign hitUs = paddr >= ADDR_USER && paddr < ADDR_USEND;
    assign setup = psel && !penable;
    assign wrEn  = psel && penable && pready && pwrite && rdHit;

    always_comb begin
        rdData = '0;
        rdHit  = paddr[IDX_LSB-1:0] == '0;
        if (hitCw) begin
            rdData[CODE_W-1:0] = cwDest_q[cwIdx];
        end else if (hitDi) begin
            rdData[CODE_W-1:0] = diDest_q[diIdx];
        end else if (hitUs) begin
            rdData = user_q[usIdx*32 +: 32];
        end else begin
            case (paddr)
                ADDR_CTRL:   rdData[1:0]      = srcSel_q;
                ADDR_CWDIG:  rdData[NBIT-1:0] = cwDig_q;
                ADDR_PADB:   rdData[NBIT-1:0] = padB_q;
                ADDR_CWMON:  rdData[NBIT-1:0] = cwMon_q;
                ADDR_PADA:   rdData[NBIT-1:0] = padABase_q;
                ADDR_PADMON: rdData[NBIT-1:0] = padAWord;
                default: begin
                    if (paddr >= ADDR_CMDMON && paddr < ADDR_PADMON) begin
                        rdData = cmdState_q[(paddr - ADDR_CMDMON) * 8 +: 32];
                    end else begin
                        rdHit = 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // APB answer: one wait-free access after each setup
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !rdHit;
            if (setup) begin
                prdata <= rdHit ? rdData : '0;
            end
        end
    end

    // ==========================================================
    // Plain control registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            srcSel_q   <= SRC_OFF;
            cwDig_q    <= '0;
            padABase_q <= '0;
            padB_q     <= '0;
            user_q     <= '0;
        end else if (wrEn) begin
            if (hitUs) begin
                user_q[usIdx*32 +: 32] <= pwdata;
            end
            case (paddr)
                ADDR_CTRL:  srcSel_q   <= cwbr_src_type'(pwdata[1:0]);
                ADDR_CWDIG: cwDig_q    <= pwdata[NBIT-1:0];
                ADDR_PADB:  padB_q     <= pwdata[NBIT-1:0];
                ADDR_PADA:  padABase_q <= pwdata[NBIT-1:0];
                default:    ;
            endcase
        end
    end

    // ==========================================================
    // Destination selectors with mutual exclusion
    logic [CODE_W-1:0] wrCode;
    assign wrCode = pwdata[CODE_W-1:0];

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cwDest_q <= '0;
            diDest_q <= '0;
        end else if (wrEn && hitCw) begin
            cwDest_q[cwIdx] <= wrCode; // RULE1
            for (int j = 0; j < NDI; j++) begin
                if (wrCode != DEST_OFF && diDest_q[j] == wrCode) begin
                    diDest_q[j] <= DEST_OFF; // RULE19
                end
            end
        end else if (wrEn && hitDi) begin
            diDest_q[diIdx] <= wrCode;
            for (int j = 0; j < NBIT; j++) begin
                if (wrCode != DEST_OFF && cwDest_q[j] == wrCode) begin
                    cwDest_q[j] <= DEST_OFF; // RULE19
                end
            end
        end
    end

    // ==========================================================
    // Source select and routing
    logic [NBIT-1:0] cwWord;

    always_comb begin
        case (srcSel_q)
            SRC_DIG:  cwWord = cwDig_q;
            SRC_PADA: cwWord = padABase_q;
            SRC_PADB: cwWord = padB_q;
            default:  cwWord = '0;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cwMon_q <= '0;
        end else begin
            cwMon_q <= cwWord; // RULE22
        end
    end

    cwbr_route_if cwRt ();
    cwbr_route_if diRt ();

    cwbr_route #(.NSRC(NBIT)) uCwRoute (
        .srcWord (cwWord),
        .srcDest (cwDest_q),
        .routeEn (srcSel_q != SRC_OFF),
        .rt      (cwRt)
    );

    cwbr_route #(.NSRC(NDI)) uDiRoute (
        .srcWord (diSync2_q),
        .srcDest (diDest_q),
        .routeEn (1'b1),
        .rt      (diRt)
    );

    logic [NDEST-1:0] validMask;
    always_comb begin
        for (int n = 0; n < NDEST; n++) begin
            validMask[n] = cwbr_valid(CODE_W'(n));
        end
    end

    // Control word first, then digital inputs, then the user parameter
    // User bits of undefined codes are stored but must stay inert
    logic [NDEST-1:0] cmd_d;
    assign cmd_d = (cwRt.drv & cwRt.val)
                 | (~cwRt.drv & diRt.drv & diRt.val)
                 | (~cwRt.drv & ~diRt.drv & user_q & validMask); // RULE20 RULE21 RULE23

    // ==========================================================
    // Command outputs, all registered
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmdState_q           <= '0;
            mpotCmd              <= '0;
            jogCmd               <= '0;
            alarmResetReq        <= 1'b0;
            trqReduct            <= 1'b0;
            rampCmd              <= '0;
            spdRegCmd            <= '0;
            anSignSel            <= '0;
            zeroTorque           <= 1'b0;
            multiSpeedSel        <= '0;
            multiRampSel         <= '0;
            fieldLossExt         <= 1'b0;
            regEnable            <= '0;
            padAWord             <= '0;
            dirCmd               <= '0;
            anEnable             <= '0;
            droopEnable          <= 1'b0;
            digModeCmd           <= '0;
            brakeFbk             <= 1'b0;
            adaptSel             <= '0;
            extFieldCtrlEnable   <= 1'b0;
            extFieldInvSeq       <= 1'b0;
            extFieldActiveBridge <= 1'b0;
        end else begin
            cmdState_q    <= cmd_d; // RULE20
            mpotCmd       <= cmd_d[DEST_MPOT +: 4]; // RULE3
            jogCmd        <= cmd_d[DEST_JOG +: 2]; // RULE4
            // Reset is held off while the alarm source is still present
            alarmResetReq <= cmd_d[DEST_ALARM_RST] && !alarmSync2_q; // RULE5
            trqReduct     <= cmd_d[DEST_TRQ_REDUCT]; // RULE16
            rampCmd       <= cmd_d[DEST_RAMP +: 3]; // RULE6
            spdRegCmd     <= cmd_d[DEST_SPDREG +: 3]; // RULE7
            anSignSel     <= cmd_d[DEST_AN_SIGN +: 6]; // RULE8
            zeroTorque    <= cmd_d[DEST_ZERO_TRQ]; // RULE16
            multiSpeedSel <= cmd_d[DEST_MULTI_SPD +: 3]; // RULE9
            multiRampSel  <= cmd_d[DEST_MULTI_RAMP +: 2]; // RULE10
            fieldLossExt  <= cmd_d[DEST_FIELD_LOSS]; // RULE16
            regEnable     <= cmd_d[DEST_REG_EN +: 4]; // RULE15
            dirCmd        <= cmd_d[DEST_DIR +: 2]; // RULE12
            anEnable      <= cmd_d[DEST_AN_EN +: 3]; // RULE13
            droopEnable   <= cmd_d[DEST_DROOP]; // RULE13
            digModeCmd    <= cmd_d[DEST_DIG_MODE +: 3]; // RULE14
            brakeFbk      <= cmd_d[DEST_BRAKE]; // RULE17
            adaptSel      <= cmd_d[DEST_ADAPT +: 2]; // RULE17
            extFieldCtrlEnable   <= cmd_d[DEST_EXT_FIELD]; // RULE18
            extFieldInvSeq       <= cmd_d[DEST_EXT_FIELD + 7'h01]; // RULE18
            extFieldActiveBridge <= cmd_d[DEST_EXT_BRIDGE]; // RULE18
            // Unforced bits keep the software base value
            for (int i = 0; i < NBIT; i++) begin
                padAWord[i] <= (cwRt.drv[DEST_PADA + i] || diRt.drv[DEST_PADA + i])
                             ? cmd_d[DEST_PADA + i] : padABase_q[i]; // RULE11
            end
        end
    end

    // ==========================================================
    // Checks
    logic dupFound;
    always_comb begin
        dupFound = 1'b0;
        for (int b = 0; b < NBIT; b++) begin
            for (int j = 0; j < NDI; j++) begin
                if (cwDest_q[b] != DEST_OFF && cwDest_q[b] == diDest_q[j]) begin
                    dupFound = 1'b1;
                end
            end
        end
    end

    chk_no_dup_dest: assert property (@(posedge mclk) disable iff (sys_rst) // RULE19
        !dupFound) else $error("same destination on control bit and digital input");
    chk_mon_off_zero: assert property (@(posedge mclk) disable iff (sys_rst) // RULE22
        srcSel_q == SRC_OFF |=> cwMon_q == '0) else $error("monitor not zero with source off");
    chk_mon_dig_copy: assert property (@(posedge mclk) disable iff (sys_rst) // RULE22
        srcSel_q == SRC_DIG |=> cwMon_q == $past(cwDig_q)) else $error("monitor not source word");
    chk_alarm_gate: assert property (@(posedge mclk) disable iff (sys_rst) // RULE5
        alarmSync2_q |=> !alarmResetReq) else $error("alarm reset while alarm active");
    chk_cw_overrides: assert property (@(posedge mclk) disable iff (sys_rst) // RULE20
        cwRt.drv[DEST_ZERO_TRQ] |=> zeroTorque == $past(cwRt.val[DEST_ZERO_TRQ]))
        else $error("zero torque not following control bit");
    chk_user_fallback: assert property (@(posedge mclk) disable iff (sys_rst) // RULE21
        !cwRt.drv[DEST_RAMP] && !diRt.drv[DEST_RAMP] |=> rampCmd[0] == $past(user_q[DEST_RAMP]))
        else $error("ramp command not following user parameter");
    chk_undef_quiet: assert property (@(posedge mclk) disable iff (sys_rst) // RULE2 RULE23
        !cmdState_q[DEST_OFF] && !cmdState_q[DEST_TRQ_REDUCT + 7'h01]
        && cmdState_q[DEST_DIR - 7'h01 : DEST_PADA_LAST + 7'h01] == '0)
        else $error("undefined destination active");
    chk_speed_sel: assert property (@(posedge mclk) disable iff (sys_rst) // RULE9
        cwRt.drv[DEST_MULTI_SPD] |=> multiSpeedSel[0] == $past(cwRt.val[DEST_MULTI_SPD]))
        else $error("multi speed mismatch");
    chk_apb_ready: assert property (@(posedge mclk) disable iff (sys_rst)
        setup |=> pready ##1 !pready) else $error("apb answer timing wrong");

endmodule : cwbr_router

// ==== tb/cwbr_drive_model.sv ====
// Model of the drive side: digital input pins and the alarm condition.
// Assumes the bench asks for pin levels; they reach the pins one edge later.
`timescale 1ns/100ps
module cwbr_drive_model
    import cwbr_pkg::*;
(
    // Clock and requests from the bench
    input  wire logic           mclk,
    input  wire logic [NDI-1:0] diReq,
    input  wire logic           alarmReq,
    // Pins seen by the router
    output logic      [NDI-1:0] diPin,
    output logic                alarmActive
);
    // ==========================================================
    // Pins
    // Registered so that pin edges never coincide with bench drives
    always_ff @(posedge mclk) begin
        diPin       <= diReq;
        alarmActive <= alarmReq;
    end
endmodule : cwbr_drive_model

// ==== tb/testbench.sv ====
// Self-checking bench for the control word bit router.
// Assumes the router answers APB after one wait-free access cycle.
`timescale 1ns/100ps
module testbench;
    import cwbr_pkg::*;
    typedef struct packed {logic [6:0] lo; logic [6:0] hi; logic on;} cwbr_row_type;
    logic        mclk, sys_rst, psel, penable, pwrite, pslverr, pready, er;
    logic        alarmReq, alarmActive;
    wire  [95:0] outs;
    logic [7:0]  paddr, diReq, diPin;
    logic [31:0] pwdata, prdata, rd;
    logic [95:0] mon;
    int          mismatches, comparisons;
    // Code ranges beside whether they drive a command
    cwbr_row_type rows [10] = '{'{1,8,1}, '{9,9,0}, '{10,48,1}, '{49,67,0}, '{68,76,1},
        '{77,83,0}, '{84,84,1}, '{85,85,0}, '{86,90,1}, '{91,127,0}};

    cwbr_router dut (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .diPin(diPin), .alarmActive(alarmActive), .mpotCmd(outs[4:1]),
        .jogCmd(outs[6:5]), .alarmResetReq(outs[7]), .trqReduct(outs[8]),
        .rampCmd(outs[12:10]), .spdRegCmd(outs[15:13]), .anSignSel(outs[21:16]),
        .zeroTorque(outs[22]), .multiSpeedSel(outs[25:23]), .multiRampSel(outs[27:26]),
        .fieldLossExt(outs[28]), .regEnable(outs[32:29]), .padAWord(outs[48:33]),
        .dirCmd(outs[69:68]), .anEnable(outs[72:70]), .droopEnable(outs[73]),
        .digModeCmd(outs[76:74]), .brakeFbk(outs[84]), .adaptSel(outs[87:86]),
        .extFieldCtrlEnable(outs[88]), .extFieldInvSeq(outs[89]),
        .extFieldActiveBridge(outs[90]));
    // Outputs laid out by destination code; codes without an output read zero
    assign {outs[95:91], outs[85], outs[83:77], outs[67:49], outs[9], outs[0]} = 34'h0_0000_0000;
    cwbr_drive_model model (.mclk(mclk), .diReq(diReq), .alarmReq(alarmReq), .diPin(diPin),
        .alarmActive(alarmActive));

    // ==========================================================
    // Tasks
    task automatic check(input logic [95:0] seen, input logic [95:0] expv);
        comparisons++;
        if (seen !== expv) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check

    // Waits on pready as long as it takes; only the watchdog ends a dead slave
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        {paddr, pwrite, pwdata, psel, penable} <= {a, w, d, 2'b10};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask : settle

    task automatic summarize;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // ==========================================================
    // Clock, watchdog, sequence
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        settle(30000);
        mismatches++;
        summarize();
    end

    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'b1000, 8'h00, 32'h0000_0000};
        {diReq, alarmReq} = 9'h000;
        settle(2);
        sys_rst <= 1'b0;
        apb(ADDR_CWMON, 1'b0, 32'h0000_0000);
        check(rd, 96'h0);
        apb(ADDR_CWDIG, 1'b1, 32'h0000_0001);
        apb(ADDR_CTRL, 1'b1, 32'h0000_0001);
        foreach (rows[r]) begin
            for (int c = rows[r].lo; c <= rows[r].hi; c++) begin
                apb(ADDR_CWDEST, 1'b1, 32'(c));
                settle(2);
                apb(ADDR_CMDMON, 1'b0, 32'h0000_0000);
                mon[31:0] = rd;
                apb(ADDR_CMDMON + 8'h04, 1'b0, 32'h0000_0000);
                mon[63:32] = rd;
                apb(ADDR_CMDMON + 8'h08, 1'b0, 32'h0000_0000);
                mon[95:64] = rd;
                check(mon, rows[r].on ? (96'h1 << c) : 96'h0);
                check(outs, rows[r].on ? (96'h1 << c) : 96'h0);
            end
        end
        apb(ADDR_CWDIG, 1'b1, 32'h0000_A5A4);
        apb(ADDR_CWMON, 1'b0, 32'h0000_0000);
        check(rd, 96'hA5A4);
        apb(ADDR_PADB, 1'b1, 32'h0000_1234);
        apb(ADDR_CTRL, 1'b1, 32'h0000_0003);
        apb(ADDR_CWMON, 1'b1, 32'h0000_FFFF);
        apb(ADDR_CWMON, 1'b0, 32'h0000_0000);
        check(rd, 96'h1234);
        apb(ADDR_PADA, 1'b1, 32'h0000_0055);
        apb(ADDR_CTRL, 1'b1, 32'h0000_0002);
        apb(ADDR_CWMON, 1'b0, 32'h0000_0000);
        check(rd, 96'h55);
        check(outs[48:33], 96'h55);
        apb(ADDR_USER, 1'b1, 32'h0040_0000);
        apb(ADDR_CWDEST, 1'b1, 32'h0000_0016);
        apb(ADDR_CTRL, 1'b1, 32'h0000_0000);
        settle(2);
        check(outs[22], 96'h1);
        apb(ADDR_CTRL, 1'b1, 32'h0000_0001);
        settle(2);
        check(outs[22], 96'h0);
        apb(ADDR_DIDEST, 1'b1, 32'h0000_0016);
        apb(ADDR_CWDEST, 1'b0, 32'h0000_0000);
        check(rd, 96'h0);
        settle(4);
        check(outs[22], 96'h0);
        diReq <= 8'h01;
        settle(6);
        check(outs[22], 96'h1);
        apb(ADDR_CWDEST, 1'b1, 32'h0000_0016);
        apb(ADDR_DIDEST, 1'b0, 32'h0000_0000);
        check(rd, 96'h0);
        apb(ADDR_CWDEST, 1'b1, 32'h0000_0007);
        // Alarm raised before the routed bit goes high, so no reset pulse may slip out
        alarmReq <= 1'b1;
        apb(ADDR_CWDIG, 1'b1, 32'h0000_0001);
        settle(5);
        check(outs[7], 96'h0);
        alarmReq <= 1'b0;
        settle(5);
        check(outs[7], 96'h1);
        apb(8'hFC, 1'b0, 32'h0000_0000);
        check(er, 96'h1);
        sys_rst <= 1'b1;
        settle(2);
        check(outs, 96'h0);
        sys_rst <= 1'b0;
        apb(ADDR_CWDEST, 1'b0, 32'h0000_0000);
        check(rd, 96'h0);
        apb(ADDR_CWMON, 1'b0, 32'h0000_0000);
        check(rd, 96'h0);
        summarize();
    end
endmodule : testbench
